// File: logic/asv_adc_sequencer.sv
// Conversion sequencer, value registers and voltage-ID capture.
// Assumes the analog front end returns a settled 10-bit code on adcCode for
// the channel on adcChannel, and that register reads and writes arrive as
// single-cycle strobes from the serial-bus engine, one at a time.
`timescale 1ns/1ps

// Operation
// - With averaging on, store the mean of sixteen conversions, never one raw sample.
// - Control bit 4 set turns averaging off; each conversion stored directly.
// - Round-robin passes start no more often than every 146.5 ms; a default averaged pass over all channels takes 300.8 ms.
// - Unaveraged slots: 0.7 ms voltage, 7 ms remote, 1.3 ms local temperature.
// - Cycle-extension bit 7 set lengthens the minimum round-robin cycle to 240 ms.
// - Control bit 5 bypasses attenuators on all five voltage inputs.
// - Bypass-register bits 7..4 bypass 12 V, 5 V, core, 2.5 V attenuators singly.
// - Control bit 6 stops cycling; only the selected channel is converted.
// - In single-channel mode the selected input updates every 0.7 ms.
// - Fan-limit bits 7..5 pick the single channel in select-code order.
// - Select field lives in the fan-1 minimum high limit; writing changes both.
// - Stored code is unsigned 10-bit, 768 nominal, saturating at 1023.
// - Voltage-ID bits 4..0 show the live levels of five dedicated pins.
// - Bit 5 reads 0 in 12 V mode, else shows the shared pin level.
// - Voltage-ID bit 7 chooses 12 V input or sixth voltage-ID input.
// - An averaged voltage takes sixteen 0.7 ms conversions, about 11 ms.
// - Reading an extended byte freezes matching value registers until read.
module asv_adc_sequencer
#(
   parameter int VoltCycles = asv_pkg::VOLT_CYC,
   parameter int RemoteCycles = asv_pkg::REMOTE_CYC,
   parameter int LocalCycles = asv_pkg::LOCAL_CYC,
   parameter int CycleCycles = asv_pkg::CYCLE_CYC,
   parameter int CycleExtCycles = asv_pkg::CYCLE_EXT_CYC
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [7:0] regRdData,
   input wire logic [9:0] adcCode,
   output logic [2:0] adcChannel,
   output logic [4:0] attenBypass,
   output logic sampleStrobe,
   input wire logic [4:0] voltIdPins,
   input wire logic voltIdBit5Shared,
   output logic sharedPinFunctionSelect,
   output logic voltIdThreshold,
   output logic [7:0] fan1MinHigh
);
   import asv_pkg::*;

   logic [7:0] cycleExt_reg;
   logic [7:0] adcCtrl_reg;
   logic [7:0] attenByp_reg;
   logic [7:0] fan1MinHi_reg;
   logic [1:0] voltIdCfg_reg;
   logic [5:0] voltIdLive_reg;
   logic [9:0] value_reg [8];
   logic [7:0] freeze_reg;
   logic [7:0] rdData_reg;
   logic [7:0] rdData_next;
   asv_state_t state_reg;
   logic [2:0] chan_reg;
   logic [24:0] slotCnt_reg;
   logic [24:0] periodCnt_reg;
   logic [3:0] sampleCnt_reg;
   logic [13:0] accum_reg;
   logic singlePrev_reg;
   logic [4:0] byp_reg;
   logic strobe_reg;

   logic singleMode;
   logic avgOn;
   logic [2:0] selField;
   logic [24:0] slotLast;
   logic [24:0] periodLast;
   logic slotEnd;
   logic lastSample;
   logic [13:0] sum;
   logic [9:0] result;
   logic passDone;
   logic [2:0] nextChan;
   logic modeChange;

   assign singleMode = adcCtrl_reg[SINGLE_BIT];
   assign selField = fan1MinHi_reg[7:SEL_LSB];
   // Single-channel mode always runs unaveraged 0.7 ms slots
   assign avgOn = !adcCtrl_reg[AVG_OFF_BIT] && !singleMode;
   assign modeChange = singleMode != singlePrev_reg;

   // Slot length by channel; averaging repeats the slot sixteen times
   always_comb
   begin
      if (singleMode || chan_reg < CH_REMOTE1)
      begin
         slotLast = 25'(VoltCycles - 1);
      end
      else if (chan_reg == CH_LOCAL)
      begin
         slotLast = 25'(LocalCycles - 1);
      end
      else
      begin
         slotLast = 25'(RemoteCycles - 1);
      end
   end

   // Pass period chosen by the extension bit
   assign periodLast = cycleExt_reg[CYCLE_EXT_BIT] ?
      25'(CycleExtCycles - 1) : 25'(CycleCycles - 1);

   assign slotEnd = state_reg == SEQ_CONV && slotCnt_reg == slotLast;
   assign lastSample = !avgOn || sampleCnt_reg == AVG_LAST;
   assign sum = accum_reg + {4'h0, adcCode};
   // Mean of sixteen is the sum shifted by four; raw code otherwise
   assign result = avgOn ? sum[13:4] : adcCode;

   // Next channel; the 12 V slot is skipped while the pin reads voltage ID
   always_comb
   begin
      nextChan = chan_reg + 3'h1;
      passDone = 1'b0;
      if (chan_reg == CH_REMOTE2)
      begin
         nextChan = CH_2V5;
         passDone = 1'b1;
      end
      else if (nextChan == CH_12V && voltIdCfg_reg[1])
      begin
         nextChan = CH_REMOTE1;
      end
   end

   // Configuration registers written by the host
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         cycleExt_reg <= RST_CYCLE_EXT;
         adcCtrl_reg <= RST_ADC_CTRL;
         attenByp_reg <= RST_ATTEN_BYP;
         fan1MinHi_reg <= RST_FAN1_MIN_HI;
         voltIdCfg_reg <= RST_VOLT_ID_CFG;
      end
      else if (regWrEn)
      begin
         case (regAddr)
            ADDR_CYCLE_EXT: cycleExt_reg <= regWrData;
            ADDR_ADC_CTRL: adcCtrl_reg <= regWrData;
            ADDR_ATTEN_BYP: attenByp_reg <= regWrData;
            ADDR_FAN1_MIN_HI: fan1MinHi_reg <= regWrData;
            ADDR_VOLT_ID:
               voltIdCfg_reg <= {regWrData[SHARED_SEL_BIT],
                                 regWrData[THRESH_BIT]};
            default: ;
         endcase
      end
   end

   // Voltage-ID pins captured every cycle so reads show live levels
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         voltIdLive_reg <= 6'h00;
      end
      else
      begin
         voltIdLive_reg[4:0] <= voltIdPins;
         // Shared pin reads zero while it is the 12 V input
         voltIdLive_reg[SHARED_ID_BIT] <=
            voltIdCfg_reg[1] && voltIdBit5Shared;
      end
   end

   // Sequencer: slot timer, sample count, channel and pass period
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state_reg <= SEQ_CONV;
         chan_reg <= CH_2V5;
         slotCnt_reg <= 25'h0000000;
         periodCnt_reg <= 25'h0000000;
         sampleCnt_reg <= 4'h0;
         accum_reg <= 14'h0000;
         singlePrev_reg <= 1'b0;
      end
      else
      begin
         singlePrev_reg <= singleMode;
         periodCnt_reg <= periodCnt_reg + 25'h0000001;
         if (modeChange)
         begin
            // Restart cleanly on entering or leaving single mode
            state_reg <= SEQ_CONV;
            chan_reg <= singleMode ? selField : CH_2V5;
            slotCnt_reg <= 25'h0000000;
            periodCnt_reg <= 25'h0000000;
            sampleCnt_reg <= 4'h0;
            accum_reg <= 14'h0000;
         end
         else
         begin
            case (state_reg)
               SEQ_CONV:
               begin
                  if (slotEnd)
                  begin
                     slotCnt_reg <= 25'h0000000;
                     if (!lastSample)
                     begin
                        sampleCnt_reg <= sampleCnt_reg + 4'h1;
                        accum_reg <= sum;
                     end
                     else
                     begin
                        sampleCnt_reg <= 4'h0;
                        accum_reg <= 14'h0000;
                        if (singleMode)
                        begin
                           chan_reg <= selField;
                        end
                        else
                        begin
                           chan_reg <= nextChan;
                           // Start the next pass only when the period is up
                           if (passDone && periodCnt_reg < periodLast)
                           begin
                              state_reg <= SEQ_WAIT;
                           end
                           else if (passDone)
                           begin
                              periodCnt_reg <= 25'h0000000;
                           end
                        end
                     end
                  end
                  else
                  begin
                     slotCnt_reg <= slotCnt_reg + 25'h0000001;
                  end
               end
               SEQ_WAIT:
               begin
                  if (periodCnt_reg >= periodLast)
                  begin
                     state_reg <= SEQ_CONV;
                     periodCnt_reg <= 25'h0000000;
                  end
               end
               default:
               begin
                  state_reg <= SEQ_CONV;
               end
            endcase
         end
      end
   end

   // Value store, one entry per channel; frozen entries hold their code
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : gValue
         always_ff @(posedge clock or posedge reset)
         begin
            if (reset)
            begin
               value_reg[gi] <= 10'h000;
            end
            else if (slotEnd && lastSample && !modeChange
                     && chan_reg == 3'(gi) && !freeze_reg[gi])
            begin
               value_reg[gi] <= result;
            end
         end
      end
   endgenerate

   // Freeze set by an extended-byte read, released by the value read
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         freeze_reg <= 8'h00;
      end
      else if (regRdEn)
      begin
         if (regAddr == ADDR_EXT_RES1)
         begin
            freeze_reg[3:0] <= 4'hF;
         end
         else if (regAddr == ADDR_EXT_RES2)
         begin
            freeze_reg[7:4] <= 4'hF;
         end
         else if (regAddr >= ADDR_VALUE_BASE && regAddr <= ADDR_VALUE_LAST)
         begin
            freeze_reg[regAddr[2:0]] <= 1'b0;
         end
      end
   end

   // Read multiplexer; unmapped offsets read zero
   always_comb
   begin
      rdData_next = 8'h00;
      if (regAddr >= ADDR_VALUE_BASE && regAddr <= ADDR_VALUE_LAST)
      begin
         rdData_next = value_reg[regAddr[2:0]][9:2];
      end
      else
      begin
         case (regAddr)
            ADDR_CYCLE_EXT: rdData_next = cycleExt_reg;
            ADDR_ADC_CTRL: rdData_next = adcCtrl_reg;
            ADDR_ATTEN_BYP: rdData_next = attenByp_reg;
            ADDR_FAN1_MIN_HI: rdData_next = fan1MinHi_reg;
            ADDR_VOLT_ID:
               rdData_next = {voltIdCfg_reg, voltIdLive_reg};
            ADDR_EXT_RES1:
               rdData_next = {value_reg[3][1:0], value_reg[2][1:0],
                              value_reg[1][1:0], value_reg[0][1:0]};
            ADDR_EXT_RES2:
               rdData_next = {value_reg[7][1:0], value_reg[6][1:0],
                              value_reg[5][1:0], value_reg[4][1:0]};
            default: rdData_next = 8'h00;
         endcase
      end
   end

   // Read data held from one read strobe to the next
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rdData_reg <= 8'h00;
      end
      else if (regRdEn)
      begin
         rdData_reg <= rdData_next;
      end
   end

   // Attenuator controls: global bypass or the per-channel bits
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         byp_reg <= 5'h00;
         strobe_reg <= 1'b0;
      end
      else
      begin
         byp_reg[CH_2V5] <= adcCtrl_reg[BYP_ALL_BIT]
            || attenByp_reg[BYP_2V5_BIT];
         byp_reg[CH_CORE] <= adcCtrl_reg[BYP_ALL_BIT]
            || attenByp_reg[BYP_CORE_BIT];
         // The supply input has no individual bypass
         byp_reg[CH_SUPPLY] <= adcCtrl_reg[BYP_ALL_BIT];
         byp_reg[CH_5V] <= adcCtrl_reg[BYP_ALL_BIT]
            || attenByp_reg[BYP_5V_BIT];
         byp_reg[CH_12V] <= adcCtrl_reg[BYP_ALL_BIT]
            || attenByp_reg[BYP_12V_BIT];
         strobe_reg <= slotEnd && !modeChange;
      end
   end

   assign regRdData = rdData_reg;
   assign adcChannel = chan_reg;
   assign attenBypass = byp_reg;
   assign sampleStrobe = strobe_reg;
   assign sharedPinFunctionSelect = voltIdCfg_reg[1];
   assign voltIdThreshold = voltIdCfg_reg[0];
   assign fan1MinHigh = fan1MinHi_reg;
endmodule

// File: logic/asv_pkg.sv
// Constants for the ADC sequencer and voltage-ID monitor block.
// Assumes a 100 MHz device clock and byte-wide internal register access.
package asv_pkg;
   // Clock rate
   localparam int CLK_KHZ = 100000;

   // Register offsets
   localparam logic [7:0] ADDR_CYCLE_EXT = 8'h10;
   localparam logic [7:0] ADDR_VALUE_BASE = 8'h20;
   localparam logic [7:0] ADDR_VALUE_LAST = 8'h27;
   localparam logic [7:0] ADDR_VOLT_ID = 8'h43;
   localparam logic [7:0] ADDR_FAN1_MIN_HI = 8'h55;
   localparam logic [7:0] ADDR_ADC_CTRL = 8'h73;
   localparam logic [7:0] ADDR_EXT_RES1 = 8'h76;
   localparam logic [7:0] ADDR_EXT_RES2 = 8'h77;
   localparam logic [7:0] ADDR_ATTEN_BYP = 8'h7D;

   // Field positions
   localparam int CYCLE_EXT_BIT = 7;
   localparam int AVG_OFF_BIT = 4;
   localparam int BYP_ALL_BIT = 5;
   localparam int SINGLE_BIT = 6;
   localparam int SEL_LSB = 5;
   localparam int SHARED_SEL_BIT = 7;
   localparam int THRESH_BIT = 6;
   localparam int SHARED_ID_BIT = 5;
   localparam int BYP_2V5_BIT = 4;
   localparam int BYP_CORE_BIT = 5;
   localparam int BYP_5V_BIT = 6;
   localparam int BYP_12V_BIT = 7;

   // Reset values
   localparam logic [7:0] RST_CYCLE_EXT = 8'h00;
   localparam logic [7:0] RST_ADC_CTRL = 8'h00;
   localparam logic [7:0] RST_ATTEN_BYP = 8'h00;
   localparam logic [7:0] RST_FAN1_MIN_HI = 8'hFF;
   localparam logic [1:0] RST_VOLT_ID_CFG = 2'h0;

   // Channel codes, in select-field order
   localparam logic [2:0] CH_2V5 = 3'h0;
   localparam logic [2:0] CH_CORE = 3'h1;
   localparam logic [2:0] CH_SUPPLY = 3'h2;
   localparam logic [2:0] CH_5V = 3'h3;
   localparam logic [2:0] CH_12V = 3'h4;
   localparam logic [2:0] CH_REMOTE1 = 3'h5;
   localparam logic [2:0] CH_LOCAL = 3'h6;
   localparam logic [2:0] CH_REMOTE2 = 3'h7;

   // Samples averaged per stored value
   localparam logic [3:0] AVG_LAST = 4'hF;

   // Times in microseconds and derived cycle counts
   localparam int T_VOLT_US = 700;
   localparam int T_REMOTE_US = 7000;
   localparam int T_LOCAL_US = 1300;
   localparam int T_CYCLE_US = 146500;
   localparam int T_CYCLE_EXT_US = 240000;
   localparam int VOLT_CYC = T_VOLT_US * CLK_KHZ / 1000;
   localparam int REMOTE_CYC = T_REMOTE_US * CLK_KHZ / 1000;
   localparam int LOCAL_CYC = T_LOCAL_US * CLK_KHZ / 1000;
   localparam int CYCLE_CYC = T_CYCLE_US * CLK_KHZ / 1000;
   localparam int CYCLE_EXT_CYC = T_CYCLE_EXT_US * CLK_KHZ / 1000;

   // Sequencer states
   typedef enum logic [1:0]
   {
      SEQ_CONV = 2'b01,
      SEQ_WAIT = 2'b10
   } asv_state_t;
endpackage

// File: test/asv_adc_sequencer_checker.sv
// Concurrent checks on the sequencer's top-level ports.
// Assumes single-cycle register strobes and bench slot lengths of 10+.
`timescale 1ns/1ps
module asv_adc_sequencer_checker
   import asv_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic [4:0] attenBypass,
   input wire logic sampleStrobe,
   input wire logic [4:0] voltIdPins,
   input wire logic voltIdBit5Shared,
   input wire logic sharedPinFunctionSelect,
   input wire logic [7:0] fan1MinHigh
);
   logic ctrlBypAll_reg;

   // Mirror of the global bypass bit; single bypasses only matter without it
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         ctrlBypAll_reg <= 1'b0;
      else if (regWrEn && regAddr == ADDR_ADC_CTRL)
         ctrlBypAll_reg <= regWrData[BYP_ALL_BIT];
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   strobe_gap_a: assert property (sampleStrobe |=> !sampleStrobe [*8])
      else $error("sample strobes closer than one voltage slot");
   // Register first, then the registered bypass output: two edges of delay
   bypass_all_a: assert property (regWrEn && regAddr == ADDR_ADC_CTRL
      && regWrData[BYP_ALL_BIT] |=> ##1 attenBypass == 5'h1F)
      else $error("global bypass not applied to all voltage inputs");
   bypass_one_a: assert property (regWrEn && regAddr == ADDR_ATTEN_BYP
      && !ctrlBypAll_reg |=> ##1 attenBypass ==
      {$past(regWrData[7:6], 2), 1'b0, $past(regWrData[5:4], 2)})
      else $error("single bypass bits mapped wrongly");
   shared_sel_a: assert property (regWrEn && regAddr == ADDR_VOLT_ID
      |=> sharedPinFunctionSelect == $past(regWrData[SHARED_SEL_BIT]))
      else $error("shared pin function select not taken");
   fan_limit_a: assert property (regWrEn && regAddr == ADDR_FAN1_MIN_HI
      |=> fan1MinHigh == $past(regWrData))
      else $error("fan limit byte not written");
   vid_live_a: assert property (regRdEn && regAddr == ADDR_VOLT_ID
      && $stable(voltIdPins) && !$past(reset)
      |=> regRdData[4:0] == $past(voltIdPins))
      else $error("voltage-ID bits differ from pins");
   vid_bit5_a: assert property (regRdEn && regAddr == ADDR_VOLT_ID
      && $stable(voltIdBit5Shared) && $stable(sharedPinFunctionSelect)
      && !$past(reset) |=> regRdData[5] ==
      ($past(voltIdBit5Shared) & $past(sharedPinFunctionSelect)))
      else $error("shared voltage-ID bit wrong for pin function");
   unmapped_rd_a: assert property (regRdEn && regAddr == 8'h00
      |=> regRdData == 8'h00)
      else $error("unmapped offset read not zero");
   rd_hold_a: assert property (!regRdEn |=> $stable(regRdData))
      else $error("read data changed without a read");

   cover property (regRdEn && regAddr == ADDR_VOLT_ID);
   cover property (sampleStrobe && fan1MinHigh[7:5] == 3'h7);
   cover property (attenBypass == 5'h1F);
endmodule

bind asv_adc_sequencer asv_adc_sequencer_checker chk_u (.clock(clock),
   .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
   .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
   .attenBypass(attenBypass), .sampleStrobe(sampleStrobe),
   .voltIdPins(voltIdPins), .voltIdBit5Shared(voltIdBit5Shared),
   .sharedPinFunctionSelect(sharedPinFunctionSelect),
   .fan1MinHigh(fan1MinHigh));

// File: test/asv_adc_model.sv
// Behavioural analog front end: one code per channel plus a dither.
// Assumes the sequencer samples adcCode in the cycle before sampleStrobe.
`timescale 1ns/1ps
module asv_adc_model
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [2:0] adcChannel,
   input wire logic sampleStrobe,
   input wire logic [9:0] shift,
   output logic [9:0] adcCode
);
   logic dither_reg;

   // Dither flips per sample so an average differs from any raw sample
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         dither_reg <= 1'b0;
      else if (sampleStrobe)
         dither_reg <= ~dither_reg;
   end

   // Nominal input everywhere but channel 7, which sits near full scale
   assign adcCode = (adcChannel == 3'h7 ? 10'h3E0 : 10'h300) + shift
      + (dither_reg ? 10'h00C : 10'h000);
endmodule

// File: test/test_asv_adc_sequencer.sv
// Register-level bench for the ADC sequencer with short slot timings.
// Assumes the front-end model in asv_adc_model.sv.
`timescale 1ns/1ps
module test_asv_adc_sequencer;
   import asv_pkg::*;
   localparam int CycN = 2000;
   localparam int CycExtN = 3000;
   logic clock, reset, regWrEn, regRdEn, voltIdBit5Shared, sampleStrobe;
   logic sharedPinFunctionSelect, voltIdThreshold;
   logic [7:0] regAddr, regWrData, regRdData, fan1MinHigh, d;
   logic [9:0] adcCode, shift;
   logic [2:0] adcChannel;
   logic [4:0] attenBypass, voltIdPins;
   int error_cnt, total_checks, cyc, t0, t1, p, i;

   asv_adc_sequencer #(.VoltCycles(10), .RemoteCycles(30),
      .LocalCycles(15), .CycleCycles(CycN), .CycleExtCycles(CycExtN))
   dut_u (.clock(clock), .reset(reset), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(regRdData), .adcCode(adcCode), .adcChannel(adcChannel),
      .attenBypass(attenBypass), .sampleStrobe(sampleStrobe),
      .voltIdPins(voltIdPins), .voltIdBit5Shared(voltIdBit5Shared),
      .sharedPinFunctionSelect(sharedPinFunctionSelect),
      .voltIdThreshold(voltIdThreshold), .fan1MinHigh(fan1MinHigh));
   asv_adc_model model_u (.clock(clock), .reset(reset),
      .adcChannel(adcChannel), .sampleStrobe(sampleStrobe), .shift(shift),
      .adcCode(adcCode));

   // Clock and a cycle count used for period measurement
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) cyc <= cyc + 1;

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         $display("mismatch %s expected %0h seen %0h", n, e, g);
         error_cnt++;
      end
   endtask

   // Strobes rise after a falling edge and drop after the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clock);
      regAddr = a;
      regWrData = v;
      regWrEn = 1'b1;
      @(negedge clock);
      regWrEn = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge clock);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clock);
      regRdEn = 1'b0;
      v = regRdData;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk($sformatf("register %0h", a), e, v);
   endtask

   // Time stamp of the sequencer entering channel 0, bounded waits
   task automatic wait_ch0(output int t);
      int n;
      for (n = 0; n < 4000 && adcChannel === 3'h0; n++) @(negedge clock);
      for (n = 0; n < 4000 && adcChannel !== 3'h0; n++) @(negedge clock);
      t = cyc;
   endtask

   task automatic strobe_gap(output int g);
      int n;
      int t;
      for (n = 0; n < 500 && sampleStrobe !== 1'b1; n++) @(negedge clock);
      t = cyc;
      @(negedge clock);
      for (n = 0; n < 500 && sampleStrobe !== 1'b1; n++) @(negedge clock);
      g = cyc - t;
   endtask

   // Hang guard, well above the expected run of about 25000 cycles
   initial
   begin
      repeat (60000) @(posedge clock);
      error_cnt++;
      wrap_up();
   end

   initial
   begin
      {regWrEn, regRdEn, regAddr, regWrData, shift, cyc} = '0;
      {error_cnt, total_checks} = '0;
      voltIdPins = 5'h15;
      voltIdBit5Shared = 1'b1;
      reset = 1'b1;
      repeat (10) @(posedge clock);
      @(negedge clock);
      reset = 1'b0;
      rchk(ADDR_CYCLE_EXT, 8'h00);
      rchk(ADDR_ADC_CTRL, 8'h00);
      rchk(ADDR_ATTEN_BYP, 8'h00);
      rchk(ADDR_FAN1_MIN_HI, 8'hFF);
      rchk(8'h00, 8'h00);
      rchk(ADDR_VOLT_ID, 8'h15);
      // Averaged values: nominal 768, or 992 on channel 7, plus half the dither
      repeat (2200) @(negedge clock);
      rchk(ADDR_VALUE_BASE, 8'hC1);
      rchk(ADDR_VALUE_LAST, 8'hF9);
      // Extended byte first holds channels 0..3 until each is read
      rchk(ADDR_EXT_RES1, 8'hAA);
      shift = 10'h004;
      repeat (4200) @(negedge clock);
      rchk(8'h21, 8'hC1);
      rchk(8'h24, 8'hC2);
      repeat (2500) @(negedge clock);
      rchk(8'h21, 8'hC2);
      wr(ADDR_ADC_CTRL, 8'h10);
      repeat (2500) @(negedge clock);
      // Channel 4 was never frozen, so it shows a fresh raw code
      rd(8'h24, d);
      chk("raw sample", 16'h1, d === 8'hC1 || d === 8'hC4);
      wait_ch0(t0);
      wait_ch0(t1);
      p = t1 - t0;
      chk("pass period", 16'h1, p == CycN || p == CycN + 1);
      wr(ADDR_CYCLE_EXT, 8'h80);
      wait_ch0(t0);
      wait_ch0(t0);
      wait_ch0(t1);
      p = t1 - t0;
      chk("long period", 16'h1, p == CycExtN || p == CycExtN + 1);
      // Bypass outputs follow the register one clock later
      wr(ADDR_ATTEN_BYP, 8'hF0);
      @(negedge clock);
      chk("single bypass", 16'h1B, attenBypass);
      wr(ADDR_ADC_CTRL, 8'h20);
      @(negedge clock);
      chk("global bypass", 16'h1F, attenBypass);
      // Every select code in single-channel mode
      wr(ADDR_ADC_CTRL, 8'h40);
      for (i = 0; i < 8; i++)
      begin
         wr(ADDR_FAN1_MIN_HI, {i[2:0], 5'h0A});
         repeat (25) @(negedge clock);
         chk("single channel", 16'(i), adcChannel);
         strobe_gap(p);
         chk("single gap", 16'd10, p);
         rchk(ADDR_FAN1_MIN_HI, {i[2:0], 5'h0A});
      end
      wr(ADDR_ADC_CTRL, 8'h00);
      @(negedge clock);
      chk("restart channel", 16'h0, adcChannel);
      // Read-only pin bits ignore the write; bit 7 picks the pin use,
      // bit 6 the input threshold
      wr(ADDR_VOLT_ID, 8'hDF);
      chk("pin select", 16'h1, sharedPinFunctionSelect);
      chk("threshold", 16'h1, voltIdThreshold);
      rchk(ADDR_VOLT_ID, 8'hF5);
      voltIdPins = 5'h0A;
      voltIdBit5Shared = 1'b0;
      repeat (3) @(negedge clock);
      rchk(ADDR_VOLT_ID, 8'hCA);
      wrap_up();
   end
endmodule
